// File: src/biphase_modem_pkg.sv
// ==========================================================================
// shared constants and types for the bi-phase bus modem
package biphase_modem_pkg;

    // receive timing, derived from the reference clock period
    localparam int REF_CLK_NS          = 100;
    localparam int RX_HALF_CELL_NS     = 400;  // half a bit cell on the bus
    localparam int RX_HALF_CYCLES      = RX_HALF_CELL_NS / REF_CLK_NS;
    localparam int RX_BIT_CYCLES       = 2 * RX_HALF_CYCLES;
    localparam int RX_LOCKOUT_CYCLES   = (3 * RX_HALF_CYCLES) / 2;
    localparam int CARRIER_LOSS_NS     = 1600; // two bit cells of silence
    localparam int CARRIER_LOSS_CYCLES = CARRIER_LOSS_NS / REF_CLK_NS;
    localparam int IDLE_GAP_NS         = 6400; // longer gap means idle
    localparam int IDLE_GAP_CYCLES     = IDLE_GAP_NS / REF_CLK_NS;

    // framing
    localparam int       PREAMBLE_BITS = 16;   // alternating 1,0,1,0...
    localparam int       PRE_MIN_ALT   = 8;    // alternations to arm hunt
    localparam int       SYNC_BITS     = 8;
    localparam logic [7:0] SYNC_WORD   = 8'hF0;
    localparam int       SOM_LEAD_BITS = 2;

    // counter widths
    localparam int GAP_W = 8;
    localparam int CNT_W = 5;

    // kind of interval seen on the bus
    typedef enum logic [1:0] {
        IV_IDLE,
        IV_TURN,
        IV_PREAMBLE,
        IV_DATA
    } interval_type;

    // transmit sequencer
    typedef enum logic [1:0] {
        TX_OFF,
        TX_PRE,
        TX_SYNC,
        TX_DATA
    } tx_state_type;

endpackage : biphase_modem_pkg

// File: src/level_sync.sv
`timescale 1ns/10ps
// ==========================================================================
// two flip-flop synchroniser with a constant reset value
module level_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic d,
    output logic      q
);
    logic meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : level_sync

// File: src/biphase_bus_modem.sv
`timescale 1ns/10ps
// How it works
// - timing and data share one bus line
// - classify bus as turn, idle, preamble, data
// - short carrier gap marks request/acknowledge turn-around
// - long silence marks the bus idle
// - preamble gives bit lock then sync word
// - back-to-back messages without idle are accepted
// - decoded bits leave serially as NRZ
// - square receive clock recovered from bus edges
// - message start low two bits before address
// - carrier detect high during any bus activity
// - receive path never touches transmit signals
// - encode using equipment transmit clock only
// - transmit enable active low, high means silent
// - while enabled, encode data onto bus
// - Manchester: mid-cell transition gives bit value
// - nominal 1.25 megabit per second bus rate
// - never transmit without reset release and enable
module biphase_bus_modem (
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    // bus side
    input  wire logic                     bus_rx_in,
    output logic                          bus_tx_data,
    output logic                          bus_tx_oe_n,
    // receive interface to the equipment
    output logic                          rx_nrz_data,
    output logic                          rx_recovered_clock,
    output logic                          message_start_n,
    output logic                          carrier_detect,
    output biphase_modem_pkg::interval_type interval_kind,
    // transmit interface from the equipment
    input  wire logic                     tx_bit_clock,
    input  wire logic                     tx_enable_n,
    input  wire logic                     tx_nrz_data
);
    import biphase_modem_pkg::*;

    // ======================================================================
    // receive path, reference clock domain
    logic             line;
    logic             line_d;
    logic             edge_seen;
    logic             accept;
    logic             sync_hit;
    logic [GAP_W-1:0] since_edge;
    logic [GAP_W-1:0] gap_cnt;
    logic [7:0]       bit_hist;
    logic [CNT_W-1:0] alt_cnt;
    logic             pre_seen;
    logic             bit_delay;
    logic [1:0]       som_cnt;

    // bus level enters through two flops, read only by the demodulator
    level_sync #(
        .RESET_VAL (1'b0)
    ) u_rx_sync (
        .clk  (ref_clk),
        .nrst (nrst),
        .d    (bus_rx_in),
        .q    (line)
    );

    // ======================================================================
    // receive path, edge timing
    // previous line level, for edge finding
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            line_d <= 1'b0;
        end else begin
            line_d <= line;
        end
    end

    assign edge_seen = line ^ line_d;
    // edges closer than 3/4 bit to a mid-cell edge are cell boundaries
    assign accept    = edge_seen &&
                       (!carrier_detect ||
                        since_edge >= GAP_W'(RX_LOCKOUT_CYCLES));
    // sync word complete right after an armed preamble
    assign sync_hit  = accept && pre_seen &&
                       ({bit_hist[6:0], line_d} == SYNC_WORD);

    // cycles since the last accepted mid-cell edge, saturating
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            since_edge <= '0;
        end else if (accept) begin
            since_edge <= '0;
        end else if (since_edge != '1) begin
            since_edge <= since_edge + GAP_W'(1);
        end
    end

    // ======================================================================
    // receive path, carrier and interval tracking
    // carrier present while mid-cell edges keep coming
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            carrier_detect <= 1'b0;
        end else if (accept) begin
            carrier_detect <= 1'b1;
        end else if (since_edge == GAP_W'(CARRIER_LOSS_CYCLES)) begin
            carrier_detect <= 1'b0;
        end
    end

    // length of the silence since carrier was lost
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gap_cnt <= '0;
        end else if (carrier_detect) begin
            gap_cnt <= '0;
        end else if (gap_cnt != GAP_W'(IDLE_GAP_CYCLES)) begin
            gap_cnt <= gap_cnt + GAP_W'(1);
        end
    end

    // interval classification
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            interval_kind <= IV_IDLE;
        end else begin
            unique case (interval_kind)
                IV_IDLE, IV_TURN: begin
                    if (accept) begin
                        interval_kind <= IV_PREAMBLE;
                    end else if (!carrier_detect &&
                                 gap_cnt == GAP_W'(IDLE_GAP_CYCLES)) begin
                        interval_kind <= IV_IDLE;
                    end
                end
                IV_PREAMBLE, IV_DATA: begin
                    if (sync_hit) begin
                        interval_kind <= IV_DATA;
                    end else if (!carrier_detect) begin
                        interval_kind <= IV_TURN;
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // receive path, bit decoding and message framing
    // decoded bit history and preamble detection
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bit_hist <= 8'h00;
            alt_cnt  <= '0;
            pre_seen <= 1'b0;
        end else if (!carrier_detect && !accept) begin
            alt_cnt  <= '0;
            pre_seen <= 1'b0;
        end else if (accept) begin
            // level before a mid-cell edge is the bit value
            bit_hist <= {bit_hist[6:0], line_d};
            if (line_d != bit_hist[0]) begin
                if (alt_cnt != '1) begin
                    alt_cnt <= alt_cnt + CNT_W'(1);
                end
            end else begin
                alt_cnt <= '0;
            end
            // re-arming in the data interval lets a new message follow
            if (sync_hit) begin
                pre_seen <= 1'b0;
            end else if (alt_cnt >= CNT_W'(PRE_MIN_ALT)) begin
                pre_seen <= 1'b1;
            end
        end
    end

    // ======================================================================
    // receive path, serial outputs to the equipment
    // data leaves one bit late so message start leads the address by two
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bit_delay   <= 1'b0;
            rx_nrz_data <= 1'b0;
        end else if (accept) begin
            bit_delay   <= line_d;
            rx_nrz_data <= bit_delay;
        end
    end

    // recovered clock: falls with each new bit, rises mid-bit
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_recovered_clock <= 1'b0;
        end else if (accept) begin
            rx_recovered_clock <= 1'b0;
        end else if (!carrier_detect) begin
            rx_recovered_clock <= 1'b0;
        end else if (since_edge == GAP_W'(RX_HALF_CYCLES - 1)) begin
            rx_recovered_clock <= 1'b1;
        end
    end

    // message start low for two output bits after sync
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            message_start_n <= 1'b1;
            som_cnt         <= 2'h0;
        end else if (sync_hit) begin
            message_start_n <= 1'b0;
            som_cnt         <= 2'(SOM_LEAD_BITS);
        end else if (!carrier_detect) begin
            message_start_n <= 1'b1;
            som_cnt         <= 2'h0;
        end else if (accept && som_cnt != 2'h0) begin
            som_cnt <= som_cnt - 2'h1;
            if (som_cnt == 2'h1) begin
                message_start_n <= 1'b1;
            end
        end
    end

    // ======================================================================
    // transmit path, equipment transmit clock domain (half-cell rate)
    logic             tx_nrst;
    logic             en_n;
    logic             half;
    logic             cell_bit;
    logic             next_bit;
    logic             cell_start;
    logic [CNT_W-1:0] tx_cnt;
    tx_state_type     tx_state;

    // reset release brought into the transmit clock domain
    level_sync #(
        .RESET_VAL (1'b0)
    ) u_tx_rst (
        .clk  (tx_bit_clock),
        .nrst (nrst),
        .d    (1'b1),
        .q    (tx_nrst)
    );

    // enable pin synchronised, resets to the silent level
    level_sync #(
        .RESET_VAL (1'b1)
    ) u_en_sync (
        .clk  (tx_bit_clock),
        .nrst (nrst),
        .d    (tx_enable_n),
        .q    (en_n)
    );

    // ======================================================================
    // transmit path, cell encoder
    // value of the cell about to start
    always_comb begin
        next_bit = 1'b1;
        unique case (tx_state)
            TX_OFF:  next_bit = 1'b1;
            TX_PRE:  next_bit = ~cell_bit;
            TX_SYNC: next_bit = SYNC_WORD[3'(SYNC_BITS - 1) - tx_cnt[2:0]];
            TX_DATA: next_bit = tx_nrz_data;
        endcase
    end

    // a cell starts on a first-half tick while enable is low
    assign cell_start = !half && !en_n;

    // half-cell phase: two ticks of the equipment clock per bit cell
    always_ff @(posedge tx_bit_clock or negedge tx_nrst) begin
        if (!tx_nrst) begin
            half <= 1'b0;
        end else if (half) begin
            half <= 1'b0;
        end else if (!en_n) begin
            half <= 1'b1;
        end
    end

    // bit of the cell in flight, held for its second half
    always_ff @(posedge tx_bit_clock or negedge tx_nrst) begin
        if (!tx_nrst) begin
            cell_bit <= 1'b0;
        end else if (cell_start) begin
            cell_bit <= next_bit;
        end
    end

    // framing sequencer: preamble count, sync word, then data
    always_ff @(posedge tx_bit_clock or negedge tx_nrst) begin
        if (!tx_nrst) begin
            tx_state <= TX_OFF;
            tx_cnt   <= '0;
        end else if (!half && en_n) begin
            // the current cell is finished, go back to silence
            tx_state <= TX_OFF;
        end else if (cell_start) begin
            unique case (tx_state)
                TX_OFF: begin
                    tx_state <= TX_PRE;
                    tx_cnt   <= CNT_W'(1);
                end
                TX_PRE: begin
                    if (tx_cnt == CNT_W'(PREAMBLE_BITS - 1)) begin
                        tx_state <= TX_SYNC;
                        tx_cnt   <= '0;
                    end else begin
                        tx_cnt <= tx_cnt + CNT_W'(1);
                    end
                end
                TX_SYNC: begin
                    if (tx_cnt == CNT_W'(SYNC_BITS - 1)) begin
                        tx_state <= TX_DATA;
                        tx_cnt   <= '0;
                    end else begin
                        tx_cnt <= tx_cnt + CNT_W'(1);
                    end
                end
                TX_DATA: begin
                    tx_cnt <= '0;
                end
            endcase
        end
    end

    // line driver: bit in the first half, inverse in the second
    always_ff @(posedge tx_bit_clock or negedge tx_nrst) begin
        if (!tx_nrst) begin
            bus_tx_data <= 1'b0;
            bus_tx_oe_n <= 1'b1;
        end else if (half) begin
            bus_tx_data <= ~cell_bit;
        end else if (en_n) begin
            bus_tx_data <= 1'b0;
            bus_tx_oe_n <= 1'b1;
        end else begin
            bus_tx_data <= next_bit;
            bus_tx_oe_n <= 1'b0;
        end
    end
endmodule : biphase_bus_modem

// File: dv/biphase_bus_modem_properties.sv
`timescale 1ns/10ps
// ============================================================
// port checker for the bi-phase bus modem
module biphase_bus_modem_checker (
    input wire logic                           ref_clk,
    input wire logic                           nrst,
    input wire logic                           bus_rx_in,
    input wire logic                           bus_tx_data,
    input wire logic                           bus_tx_oe_n,
    input wire logic                           rx_nrz_data,
    input wire logic                           rx_recovered_clock,
    input wire logic                           message_start_n,
    input wire logic                           carrier_detect,
    input wire biphase_modem_pkg::interval_type interval_kind,
    input wire logic                           tx_bit_clock,
    input wire logic                           tx_enable_n
);
    import biphase_modem_pkg::*;
    logic [7:0] som_len;  // low cycles of message start
    logic [7:0] quiet;    // cycles since the bus pin moved
    logic       rx_last;
    logic       half;     // second half of a sent cell
    // ============================================================
    // receive side counters
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            som_len <= 8'h00;
            quiet   <= 8'h00;
            rx_last <= 1'b0;
        end else begin
            som_len <= message_start_n ? 8'h00 : som_len + 8'h01;
            if (bus_rx_in != rx_last) quiet <= 8'h00;
            else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
            rx_last <= bus_rx_in;
        end
    end
    // transmit cell phase
    always_ff @(posedge tx_bit_clock or negedge nrst) begin
        if (!nrst) half <= 1'b0;
        else half <= bus_tx_oe_n ? 1'b0 : !half;
    end
    // ============================================================
    // assertions
    AST_RXDATA_ON_FALL: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        $changed(rx_nrz_data) |-> !rx_recovered_clock)
        else $error("rx data moved while rx clock high");
    AST_SOM_TWO_BITS: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        $rose(message_start_n) |-> som_len == 8'h10)
        else $error("message start low length wrong");
    AST_CARRIER_RISE: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !carrier_detect && bus_rx_in != rx_last |-> ##[1:6] carrier_detect)
        else $error("carrier detect late");
    AST_CARRIER_LOSS: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        $fell(carrier_detect) |-> quiet >= 8'h08 ##[0:2]
        interval_kind == IV_TURN)
        else $error("bad carrier loss");
    AST_IDLE_AFTER_GAP: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        interval_kind == IV_IDLE && $past(interval_kind) == IV_TURN
        |-> quiet >= 8'h40 && !carrier_detect)
        else $error("idle declared too early");
    AST_TX_NEEDS_ENABLE: assert property (
        @(posedge tx_bit_clock) disable iff (!nrst)
        $fell(bus_tx_oe_n) |-> !$past(tx_enable_n, 2))
        else $error("bus driven without enable");
    AST_TX_PREAMBLE_HEAD: assert property (
        @(posedge tx_bit_clock) disable iff (!nrst)
        $fell(bus_tx_oe_n) |-> bus_tx_data ##1 !bus_tx_data
        ##1 !bus_tx_data ##1 bus_tx_data)
        else $error("preamble does not start 1,0");
    AST_TX_MIDCELL: assert property (
        @(posedge tx_bit_clock) disable iff (!nrst)
        !bus_tx_oe_n && !half |=> bus_tx_data != $past(bus_tx_data))
        else $error("no mid-cell transition");
endmodule : biphase_bus_modem_checker

bind biphase_bus_modem biphase_bus_modem_checker u_checker (
    .ref_clk(ref_clk), .nrst(nrst), .bus_rx_in(bus_rx_in),
    .bus_tx_data(bus_tx_data), .bus_tx_oe_n(bus_tx_oe_n),
    .rx_nrz_data(rx_nrz_data),
    .rx_recovered_clock(rx_recovered_clock),
    .message_start_n(message_start_n),
    .carrier_detect(carrier_detect), .interval_kind(interval_kind),
    .tx_bit_clock(tx_bit_clock), .tx_enable_n(tx_enable_n)
);

// File: dv/equipment_model.sv
`timescale 1ns/10ps
// ============================================================
// transmit-side attached equipment
module equipment_model (
    output logic             tx_bit_clock,
    output logic             tx_enable_n,
    output logic             tx_nrz_data,
    output logic             tx_done,
    output logic [63:0]      line,
    input  wire logic        tx_go,
    input  wire logic [7:0]  payload,
    input  wire logic        bus_tx_data,
    input  wire logic        bus_tx_oe_n
);
    int tick;
    // free running half-cell clock, offset from ref_clk
    initial begin
        tx_bit_clock = 1'b0;
        tx_enable_n  = 1'b1;
        tx_nrz_data  = 1'b0;
        tx_done      = 1'b0;
        line         = '0;
        tick         = 0;
        #7;
        forever #32 tx_bit_clock = !tx_bit_clock;
    end
    // request, record driven ticks, feed data between edges
    always @(negedge tx_bit_clock) begin
        if (tx_go && !tx_done && tick == 0)
            tx_enable_n = 1'b0;
        if (!bus_tx_oe_n && tick < 64) begin
            line[tick] = bus_tx_data;
            tick = tick + 1;
            if (tick == 64) begin
                tx_enable_n = 1'b1;
                tx_done     = 1'b1;
            end
        end
        if (tick >= 48 && tick < 64)
            tx_nrz_data = payload[(tick - 48) / 2];
        else
            tx_nrz_data = tick[0];
    end
endmodule : equipment_model

// File: dv/biphase_bus_modem_tb_top.sv
`timescale 1ns/10ps
// ============================================================
// bench for the bi-phase bus modem
module biphase_bus_modem_tb_top;
    import biphase_modem_pkg::*;
    localparam logic [7:0] PAYLOAD = 8'h96;
    logic         ref_clk, nrst, bus_rx_in, bus_tx_data, bus_tx_oe_n;
    logic         rx_nrz_data, rx_recovered_clock, message_start_n;
    logic         carrier_detect, tx_bit_clock, tx_enable_n;
    logic         tx_nrz_data, tx_go, tx_done;
    logic [7:0]   cap;
    logic [63:0]  line, exp_line;
    interval_type interval_kind;
    int           n_mismatch, total_checks, n_som, som_low, cap_n;
    // ============================================================
    // design and transmit-side equipment
    biphase_bus_modem DUT (
        .ref_clk(ref_clk), .nrst(nrst), .bus_rx_in(bus_rx_in),
        .bus_tx_data(bus_tx_data), .bus_tx_oe_n(bus_tx_oe_n),
        .rx_nrz_data(rx_nrz_data),
        .rx_recovered_clock(rx_recovered_clock),
        .message_start_n(message_start_n),
        .carrier_detect(carrier_detect), .interval_kind(interval_kind),
        .tx_bit_clock(tx_bit_clock), .tx_enable_n(tx_enable_n),
        .tx_nrz_data(tx_nrz_data)
    );
    equipment_model partner (
        .tx_bit_clock(tx_bit_clock), .tx_enable_n(tx_enable_n),
        .tx_nrz_data(tx_nrz_data), .tx_done(tx_done), .line(line),
        .tx_go(tx_go), .payload(PAYLOAD), .bus_tx_data(bus_tx_data),
        .bus_tx_oe_n(bus_tx_oe_n)
    );
    // clock and receive-side monitors
    always #50 ref_clk = !ref_clk;
    always @(negedge message_start_n) n_som++;
    always @(negedge ref_clk) if (!message_start_n) som_low++;
    always @(posedge message_start_n) cap_n = 0;
    always @(posedge rx_recovered_clock) if (cap_n < 8) begin
        cap = {cap[6:0], rx_nrz_data};
        cap_n++;
    end
    // ============================================================
    // shared tasks
    task automatic check(input logic [63:0] got, input logic [63:0] want);
        total_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check
    task automatic rx_bit(input logic b);
        bus_rx_in = b;
        repeat (4) @(negedge ref_clk);
        bus_rx_in = !b;
        repeat (4) @(negedge ref_clk);
    endtask : rx_bit
    // preamble, sync word, address byte, three filler zeros
    task automatic rx_msg(input logic [7:0] addr);
        for (int k = 0; k < 16; k++) rx_bit(!k[0]);
        for (int k = 7; k >= 0; k--) rx_bit(SYNC_WORD[k]);
        for (int k = 7; k >= 0; k--) rx_bit(addr[k]);
        repeat (3) rx_bit(1'b0);
        bus_rx_in = 1'b0;
    endtask : rx_msg
    task automatic print_verdict;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // ============================================================
    // one message, then silence through turn-around into idle
    task automatic test_rx_single;
        som_low = 0;
        rx_msg(8'hA5);
        check(64'(cap), 64'hA5);
        check(64'(som_low), 64'h10);
        check(64'(carrier_detect), 64'h1);
        check(64'(interval_kind), 64'(IV_DATA));
        repeat (40) @(negedge ref_clk);
        check(64'(carrier_detect), 64'h0);
        check(64'(interval_kind), 64'(IV_TURN));
        repeat (80) @(negedge ref_clk);
        check(64'(interval_kind), 64'(IV_IDLE));
    endtask : test_rx_single
    // two messages with no idle gap between them
    task automatic test_back_to_back;
        n_som = 0;
        rx_msg(8'h3C);
        check(64'(cap), 64'h3C);
        rx_msg(8'hC3);
        check(64'(cap), 64'hC3);
        check(64'(n_som), 64'h2);
        repeat (120) @(negedge ref_clk);
    endtask : test_back_to_back
    // one transmit burst judged tick by tick at the bus pins
    task automatic test_tx;
        logic b;
        check(64'(bus_tx_oe_n), 64'h1);
        for (int c = 0; c < 32; c++) begin
            if (c < 16) b = !c[0];
            else if (c < 24) b = SYNC_WORD[23 - c];
            else b = PAYLOAD[c - 24];
            exp_line[2 * c] = b;
            exp_line[2 * c + 1] = !b;
        end
        tx_go = 1'b1;
        for (int i = 0; i < 400 && !tx_done; i++) @(negedge ref_clk);
        check(64'(tx_done), 64'h1);
        check(line, exp_line);
        repeat (20) @(negedge ref_clk);
        check(64'(bus_tx_oe_n), 64'h1);
    endtask : test_tx
    // ============================================================
    // main sequence
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        bus_rx_in = 1'b0;
        tx_go = 1'b0;
        cap = 8'h00;
        cap_n = 8;
        n_mismatch = 0;
        total_checks = 0;
        n_som = 0;
        som_low = 0;
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        test_rx_single;
        test_back_to_back;
        test_tx;
        print_verdict;
    end
endmodule : biphase_bus_modem_tb_top
